/* design/dpc_pin_ctrl.sv */
// DDR2 control, termination and strobe pin logic seen from the memory
// Function
// - Sample commands on rising true-clock crossing
// - Read data changes on both crossings
// - CKE low stops buffers, drivers; clock in self refresh only
// - CKE low picks power-down or self refresh
// - Self refresh exit needs no clock
// - Power-down keeps only clock, ODT, CKE
// - Self refresh keeps only CKE receiver
// - Chip select high masks the command
// - Command from CS, RAS, CAS, WE together
// - x4/x8 terminate DQ, strobes, mask only
// - x16 terminates both byte lanes fully
// - Termination off ignores ODT pin
// - Masked write beats are discarded
// - Mask sampled on both strobe edges
// - x8 mask pin doubles as read strobe
// - Device drives strobe only with read data
// - Precharge closes one bank or all
`timescale 1ns/1ps
`default_nettype none
module dpc_pin_ctrl #(
    parameter int DQ_W  = 8,
    parameter int BURST = dpc_pkg::BURST_BEATS,
    parameter int RL    = dpc_pkg::READ_LAT,
    parameter int DEPTH = dpc_pkg::FIFO_DEPTH
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     ck_t,
    input  wire logic                     ck_c,
    input  wire logic                     cke,
    input  wire logic                     cs_n,
    input  wire logic                     ras_n,
    input  wire logic                     cas_n,
    input  wire logic                     we_n,
    input  wire logic [dpc_pkg::BA_W-1:0] ba,
    input  wire logic [dpc_pkg::A_W-1:0]  addr,
    input  wire logic                     odt,
    input  wire logic                     dm,
    input  wire logic                     dqs_in,
    input  wire logic [DQ_W-1:0]          dq_in,
    output logic [DQ_W-1:0]               dq_out,
    output logic                          dq_oe,
    output logic                          dqs_out,
    output logic                          dqs_oe,
    output logic                          term_dq,
    output logic                          term_dqs,
    output logic                          term_dm,
    output logic                          term_rdqs,
    output logic                          term_upper,
    input  wire logic [DQ_W-1:0]          rd_data,
    output logic                          rd_beat,
    output logic                          wr_valid,
    input  wire logic                     wr_ready,
    output logic [DQ_W-1:0]               wr_data,
    output logic                          wr_overrun,
    output logic                          cmd_valid,
    output dpc_pkg::dpc_cmd_t             cmd_code,
    output logic [dpc_pkg::BA_W-1:0]      cmd_bank,
    output logic [dpc_pkg::A_W-1:0]       cmd_addr,
    output logic [(1<<dpc_pkg::BA_W)-1:0] bank_open,
    output dpc_pkg::dpc_pwr_t             pwr_state
);
    localparam int BANKS = 1 << dpc_pkg::BA_W;
    localparam int CW    = $clog2(BURST + 1);
    localparam int LW    = $clog2(RL + 1);

    typedef struct packed {
        logic                     ck_t;
        logic                     ck_c;
        logic                     cke;
        logic                     cs_n;
        logic                     ras_n;
        logic                     cas_n;
        logic                     we_n;
        logic                     odt;
        logic                     dm;
        logic                     dqs;
        logic [dpc_pkg::BA_W-1:0] ba;
        logic [dpc_pkg::A_W-1:0]  addr;
        logic [DQ_W-1:0]          dq;
    } dpc_pin_t;

    typedef struct packed {
        dpc_pin_t                 meta;
        dpc_pin_t                 pin;
        logic                     ck_hi;
        logic                     dqs_prev;
        dpc_pkg::dpc_pwr_t        pwr;
        logic [BANKS-1:0]         open;
        logic                     term_en;
        logic                     rdqs_en;
        logic                     odt_reg;
        logic                     cmd_valid;
        dpc_pkg::dpc_cmd_t        cmd;
        logic [dpc_pkg::BA_W-1:0] bank;
        logic [dpc_pkg::A_W-1:0]  addr;
        logic                     wr_act;
        logic [CW-1:0]            wr_cnt;
        logic                     rd_pend;
        logic [LW-1:0]            rd_wait;
        logic                     rd_act;
        logic [CW-1:0]            rd_cnt;
        logic [DQ_W-1:0]          dq_out;
        logic                     dq_oe;
        logic                     dqs_out;
        logic                     overrun;
    } dpc_st_t;

    dpc_st_t           st;
    dpc_st_t           next_st;
    dpc_pin_t          pins_now;
    dpc_pkg::dpc_cmd_t dec_cmd;
    logic              ck_seen;
    logic              rise;
    logic              fall;
    logic              cmd_take;
    logic              sr_entry;
    logic              dqs_edge;
    logic              wr_keep;
    logic              rd_go;
    logic              beat;
    logic              term_on;

    dpc_stream_if #(.W(DQ_W)) wq ();

    // All pins arrive from another domain and pass two flops first
    assign pins_now = '{ck_t: ck_t, ck_c: ck_c, cke: cke, cs_n: cs_n,
                        ras_n: ras_n, cas_n: cas_n, we_n: we_n, odt: odt,
                        dm: dm, dqs: dqs_in, ba: ba, addr: addr, dq: dq_in};

    // Clock receiver is dead in self refresh, alive in power-down
    assign ck_seen = (st.pwr != dpc_pkg::DPC_SELF_REF);
    assign rise = ck_seen & st.pin.ck_t & ~st.pin.ck_c & ~st.ck_hi;
    assign fall = ck_seen & ~st.pin.ck_t & st.pin.ck_c & st.ck_hi;

    // Command code from the three strobes sampled together
    always_comb begin
        unique case ({st.pin.ras_n, st.pin.cas_n, st.pin.we_n})
            dpc_pkg::RCW_MRS: dec_cmd = dpc_pkg::DPC_MRS;
            dpc_pkg::RCW_REF: dec_cmd = dpc_pkg::DPC_REF;
            dpc_pkg::RCW_PRE: dec_cmd = dpc_pkg::DPC_PRE;
            dpc_pkg::RCW_ACT: dec_cmd = dpc_pkg::DPC_ACT;
            dpc_pkg::RCW_WR:  dec_cmd = dpc_pkg::DPC_WR;
            dpc_pkg::RCW_RD:  dec_cmd = dpc_pkg::DPC_RD;
            default:          dec_cmd = dpc_pkg::DPC_NOP;
        endcase
    end

    // Command buffers only listen while fully active; CS high masks all
    assign cmd_take = rise & (st.pwr == dpc_pkg::DPC_ACTIVE)
                    & st.pin.cke & ~st.pin.cs_n;
    assign sr_entry = ~st.pin.cs_n & (dec_cmd == dpc_pkg::DPC_REF);

    // Strobe edges of either sense carry a write beat and its mask
    assign dqs_edge = (st.pwr == dpc_pkg::DPC_ACTIVE)
                    & (st.pin.dqs != st.dqs_prev);
    // With the read strobe option the pin is no longer a mask
    assign wr_keep  = ~(st.pin.dm & ~st.rdqs_en);
    assign wq.in_valid = st.wr_act & dqs_edge & wr_keep;
    assign wq.in_data  = st.pin.dq;

    // Read beats start on a rise and then follow every crossing
    assign rd_go = st.rd_pend & rise & (st.rd_wait == '0);
    assign beat  = rd_go | (st.rd_act & (rise | fall));

    always_comb begin
        next_st = st;
        next_st.meta = pins_now;
        next_st.pin  = st.meta;
        next_st.dqs_prev  = st.pin.dqs;
        next_st.cmd_valid = 1'b0;
        next_st.overrun   = 1'b0;
        if (rise) begin
            next_st.ck_hi   = 1'b1;
            next_st.odt_reg = st.pin.odt; // ODT still heard in power-down
        end else if (fall) begin
            next_st.ck_hi = 1'b0;
        end
        // Power state; CKE acts on the clock except for self refresh exit
        unique case (st.pwr)
            dpc_pkg::DPC_ACTIVE: begin
                if (rise && !st.pin.cke) begin
                    if (sr_entry && st.open == '0) begin
                        next_st.pwr = dpc_pkg::DPC_SELF_REF;
                    end else if (st.open != '0) begin
                        next_st.pwr = dpc_pkg::DPC_PD_ACT;
                    end else begin
                        next_st.pwr = dpc_pkg::DPC_PD_PRE;
                    end
                end
            end
            dpc_pkg::DPC_PD_PRE, dpc_pkg::DPC_PD_ACT: begin
                if (rise && st.pin.cke) begin
                    next_st.pwr = dpc_pkg::DPC_ACTIVE;
                end
            end
            dpc_pkg::DPC_SELF_REF: begin
                // No crossing is needed: the clock may be stopped here
                if (st.pin.cke) begin
                    next_st.pwr = dpc_pkg::DPC_ACTIVE;
                end
            end
        endcase
        // Accepted commands
        if (cmd_take) begin
            next_st.cmd_valid = 1'b1;
            next_st.cmd  = dec_cmd;
            next_st.bank = st.pin.ba;
            next_st.addr = st.pin.addr;
            unique case (dec_cmd)
                dpc_pkg::DPC_ACT: next_st.open[st.pin.ba] = 1'b1;
                dpc_pkg::DPC_PRE: begin
                    if (st.pin.addr[dpc_pkg::PRE_ALL_BIT]) begin
                        next_st.open = '0;
                    end else begin
                        next_st.open[st.pin.ba] = 1'b0;
                    end
                end
                dpc_pkg::DPC_MRS: begin
                    if (st.pin.ba == dpc_pkg::BANK_EMR1) begin
                        next_st.term_en = st.pin.addr[dpc_pkg::EMR_RTT0_BIT]
                                        | st.pin.addr[dpc_pkg::EMR_RTT1_BIT];
                        next_st.rdqs_en = st.pin.addr[dpc_pkg::EMR_RDQS_BIT]
                                        & (DQ_W == 8);
                    end
                end
                dpc_pkg::DPC_WR: begin
                    next_st.wr_act = 1'b1;
                    next_st.wr_cnt = '0;
                end
                dpc_pkg::DPC_RD: begin
                    next_st.rd_pend = 1'b1;
                    next_st.rd_wait = LW'(RL - 1);
                end
                default: begin
                end
            endcase
        end
        // Write window closes after a full burst of strobe edges
        if (st.wr_act && dqs_edge) begin
            next_st.wr_cnt = st.wr_cnt + 1'b1;
            if (st.wr_cnt == CW'(BURST - 1)) begin
                next_st.wr_act = 1'b0;
            end
            // The pins cannot be held off, so a full FIFO loses the beat
            if (wq.in_valid && !wq.in_ready) begin
                next_st.overrun = 1'b1;
            end
        end
        // Read latency counted in rising crossings
        if (st.rd_pend && rise) begin
            if (st.rd_wait == '0) begin
                next_st.rd_pend = 1'b0;
                next_st.rd_act  = 1'b1;
                next_st.rd_cnt  = '0;
            end else begin
                next_st.rd_wait = st.rd_wait - 1'b1;
            end
        end
        // Data and strobe change together on every crossing of a burst
        if (beat) begin
            next_st.dq_out  = rd_data;
            next_st.dq_oe   = 1'b1;
            next_st.dqs_out = rise;
            next_st.rd_cnt  = (rd_go ? CW'(0) : st.rd_cnt) + 1'b1;
            if ((rd_go ? CW'(0) : st.rd_cnt) == CW'(BURST - 1)) begin
                next_st.rd_act = 1'b0;
            end
        end else if (rise || fall) begin
            next_st.dq_oe   = 1'b0;
            next_st.dqs_out = 1'b0;
        end
        // Leaving the active state stops drivers and pending bursts
        if (next_st.pwr != dpc_pkg::DPC_ACTIVE) begin
            next_st.wr_act  = 1'b0;
            next_st.rd_pend = 1'b0;
            next_st.rd_act  = 1'b0;
            next_st.dq_oe   = 1'b0;
            next_st.dqs_out = 1'b0;
        end
    end

    // Asynchronous reset loads constants only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.term_en <= dpc_pkg::RST_TERM_EN;
            st.rdqs_en <= dpc_pkg::RST_RDQS_EN;
        end else begin
            st <= next_st;
        end
    end

    // Termination follows the registered pin only when enabled
    assign term_on    = st.odt_reg & st.term_en
                      & (st.pwr != dpc_pkg::DPC_SELF_REF);
    assign term_dq    = term_on;
    assign term_dqs   = term_on;
    assign term_dm    = term_on & ~st.rdqs_en;
    assign term_rdqs  = term_on & st.rdqs_en;
    assign term_upper = term_on & (DQ_W == 16);

    // Read and status outputs come from the state flops
    assign dq_out     = st.dq_out;
    assign dq_oe      = st.dq_oe;
    assign dqs_out    = st.dqs_out;
    assign dqs_oe     = st.dq_oe;
    assign rd_beat    = beat;
    assign wr_overrun = st.overrun;
    assign cmd_valid  = st.cmd_valid;
    assign cmd_code   = st.cmd;
    assign cmd_bank   = st.bank;
    assign cmd_addr   = st.addr;
    assign bank_open  = st.open;
    assign pwr_state  = st.pwr;

    // User side drains the FIFO; stalling it fills it toward overrun
    assign wr_valid     = wq.out_valid;
    assign wr_data      = wq.out_data;
    assign wq.out_ready = wr_ready;

    dpc_fifo #(
        .W     (DQ_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .sys_clk (sys_clk),
        .rst     (rst),
        .bus     (wq)
    );

    default clocking dpc_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    a_cmd_on_rise: assert property (st.cmd_valid |-> $past(rise))
        else $error("command taken away from a rising crossing");
    a_cs_masks_cmd: assert property (rise && st.pin.cs_n |=> !st.cmd_valid)
        else $error("command accepted with chip select high");
    a_act_decode: assert property (cmd_take && !st.pin.ras_n && st.pin.cas_n
        && st.pin.we_n |=> st.cmd == dpc_pkg::DPC_ACT && st.open != '0)
        else $error("activate code not decoded");
    a_drv_off_idle: assert property (st.pwr != dpc_pkg::DPC_ACTIVE
        |-> !dq_oe && !dqs_oe)
        else $error("drivers on outside active state");
    a_pd_active_kind: assert property (st.pwr == dpc_pkg::DPC_ACTIVE && rise
        && !st.pin.cke && st.open != '0 |=> st.pwr == dpc_pkg::DPC_PD_ACT)
        else $error("wrong power-down with a row open");
    a_sr_exit_async: assert property (st.pwr == dpc_pkg::DPC_SELF_REF
        && st.pin.cke |=> st.pwr == dpc_pkg::DPC_ACTIVE)
        else $error("self refresh exit waited for the clock");
    a_sr_clock_deaf: assert property (st.pwr == dpc_pkg::DPC_SELF_REF
        |=> !st.cmd_valid && $stable(st.odt_reg))
        else $error("clock heard in self refresh");
    a_odt_ignored: assert property (!st.term_en |-> !term_dq && !term_dm)
        else $error("termination applied while disabled");
    a_mask_drops: assert property (st.wr_act && dqs_edge && st.pin.dm
        && !st.rdqs_en |-> !wq.in_valid)
        else $error("masked beat reached the FIFO");
    a_pre_all_banks: assert property (cmd_take && dec_cmd == dpc_pkg::DPC_PRE
        && st.pin.addr[dpc_pkg::PRE_ALL_BIT] |=> st.open == '0)
        else $error("precharge all left a bank open");
    a_read_fall_beat: assert property (st.rd_act && fall
        |=> st.dq_oe && !st.dqs_out ##0 $past(rd_data) == dq_out)
        else $error("read beat missing on falling crossing");
endmodule
`default_nettype wire

/* design/dpc_pkg.sv */
// Shared constants and types for the DDR2 pin control block
package dpc_pkg;

    // Address and bank geometry
    localparam int BA_W        = 2;
    localparam int A_W         = 14;
    localparam int PRE_ALL_BIT = 10;

    // Mode register selection by bank address
    localparam logic [1:0] BANK_MR   = 2'h0;
    localparam logic [1:0] BANK_EMR1 = 2'h1;

    // Extended mode register field positions
    localparam int EMR_RTT0_BIT = 2;
    localparam int EMR_RTT1_BIT = 6;
    localparam int EMR_RDQS_BIT = 11;

    // Values after reset
    localparam logic RST_TERM_EN = 1'b0;
    localparam logic RST_RDQS_EN = 1'b0;

    // Burst length in clock crossings, read latency in rising crossings, FIFO depth in entries
    localparam int BURST_BEATS = 4;
    localparam int READ_LAT    = 3;
    localparam int FIFO_DEPTH  = 32;

    // Command code on {ras_n, cas_n, we_n}
    localparam logic [2:0] RCW_MRS = 3'h0;
    localparam logic [2:0] RCW_REF = 3'h1;
    localparam logic [2:0] RCW_PRE = 3'h2;
    localparam logic [2:0] RCW_ACT = 3'h3;
    localparam logic [2:0] RCW_WR  = 3'h4;
    localparam logic [2:0] RCW_RD  = 3'h5;

    typedef enum logic [1:0] {
        DPC_ACTIVE, DPC_PD_PRE, DPC_PD_ACT, DPC_SELF_REF
    } dpc_pwr_t;

    typedef enum logic [2:0] {
        DPC_NOP, DPC_ACT, DPC_RD, DPC_WR, DPC_PRE, DPC_REF, DPC_MRS
    } dpc_cmd_t;

endpackage

/* design/dpc_stream_if.sv */
// Valid/ready carrier between the pin logic and its write FIFO
`timescale 1ns/1ps
`default_nettype none
interface dpc_stream_if #(
    parameter int W = 8
);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;

    modport src (output in_valid, output in_data, input in_ready,
                 input out_valid, input out_data, output out_ready);
    modport fifo (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

/* design/dpc_fifo.sv */
// Write data FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dpc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = dpc_pkg::FIFO_DEPTH
) (
    input  wire logic     sys_clk,
    input  wire logic     rst,
    dpc_stream_if.fifo    bus
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } dpc_fifo_st_t;

    dpc_fifo_st_t st;
    dpc_fifo_st_t next_st;
    logic [W-1:0] mem [DEPTH];
    logic         push;
    logic         pop;

    // Full and empty come straight from the occupancy count
    assign bus.in_ready  = (st.cnt != (AW+1)'(DEPTH));
    assign bus.out_valid = (st.cnt != '0);
    assign bus.out_data  = mem[st.rp];
    assign push = bus.in_valid & bus.in_ready;
    assign pop  = bus.out_valid & bus.out_ready;

    // Pointers wrap naturally; depth must be a power of two
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage has no reset; only pointers and count need a defined value
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[st.wp] <= bus.in_data;
        end
    end
endmodule
`default_nettype wire

/* tb/dpc_ctrl_model.sv */
// Controller model driving the memory pins of the pin control block
`timescale 1ns/1ps
`default_nettype none
module dpc_ctrl_model (
    input  wire logic        sys_clk,
    output var  logic        ck_t,
    output      logic        ck_c,
    output var  logic        cke,
    output var  logic        cs_n,
    output var  logic        ras_n,
    output var  logic        cas_n,
    output var  logic        we_n,
    output var  logic [1:0]  ba,
    output var  logic [13:0] addr,
    output var  logic        odt,
    output var  logic        dm,
    output var  logic        dqs_in,
    output var  logic [7:0]  dq_in
);
    assign ck_c = ~ck_t;
    // Clock parked low between frames, chip deselected
    initial begin
        {ck_t, cs_n, ras_n, cas_n, we_n, cke} = 6'h1F;
        {ba, addr, odt, dm, dqs_in, dq_in} = '0;
    end
    // Pins set with the rising crossing, held three cycles per clock level
    task automatic cmd(input logic c, input logic [2:0] rcw, input logic [1:0] b,
                       input logic [13:0] a);
        @(posedge sys_clk);
        cs_n <= c;
        {ras_n, cas_n, we_n} <= rcw;
        ba <= b;
        addr <= a;
        ck_t <= 1'b1;
        repeat (3) @(posedge sys_clk);
        ck_t <= 1'b0;
        cs_n <= 1'b1;
        addr <= ~a;
        repeat (3) @(posedge sys_clk);
    endtask
    // One strobe edge per beat, mask and data change with it and then hold
    task automatic beat(input logic m, input logic [7:0] d);
        @(posedge sys_clk);
        dm <= m;
        dq_in <= d;
        dqs_in <= ~dqs_in;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic pins(input logic k, input logic o);
        @(posedge sys_clk);
        cke <= k;
        odt <= o;
    endtask
endmodule
`default_nettype wire

/* tb/dpc_pin_ctrl_tb_top.sv */
// Self-checking bench for the pin control block
`timescale 1ns/1ps
`default_nettype none
module dpc_pin_ctrl_tb_top;
    logic              sys_clk, rst, ck_t, ck_c, cke, cs_n, ras_n, cas_n, we_n, odt, dm;
    logic              dqs_in, dq_oe, dqs_out, dqs_oe, wr_valid, wr_ready, wr_overrun;
    logic              cmd_valid, rd_beat, term_dq, term_dqs, term_dm, term_rdqs, term_upper;
    logic              rd_q, mk;
    logic [1:0]        ba, cmd_bank;
    logic [13:0]       addr, cmd_addr, a;
    logic [7:0]        dq_in, dq_out, rd_data, wr_data, rd_prev, d;
    logic [3:0]        bank_open;
    logic [31:0]       seed = 32'h00000025;
    dpc_pkg::dpc_cmd_t cmd_code;
    dpc_pkg::dpc_pwr_t pwr_state;
    int                fails, n_tests, n_cmd, n_ovr, n_beat, x_ovr, c0;
    logic [7:0]        exp_q [$];

    dpc_pin_ctrl uut (.sys_clk, .rst, .ck_t, .ck_c, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
        .addr, .odt, .dm, .dqs_in, .dq_in, .dq_out, .dq_oe, .dqs_out, .dqs_oe, .term_dq,
        .term_dqs, .term_dm, .term_rdqs, .term_upper, .rd_data, .rd_beat, .wr_valid,
        .wr_ready, .wr_data, .wr_overrun, .cmd_valid, .cmd_code, .cmd_bank, .cmd_addr,
        .bank_open, .pwr_state);
    dpc_ctrl_model m (.sys_clk, .ck_t, .ck_c, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
        .addr, .odt, .dm, .dqs_in, .dq_in);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected command from the ras/cas/we code with chip selected
    function automatic dpc_pkg::dpc_cmd_t dec(input logic [2:0] r);
        case (r)
            3'h0: return dpc_pkg::DPC_MRS;
            3'h1: return dpc_pkg::DPC_REF;
            3'h2: return dpc_pkg::DPC_PRE;
            3'h3: return dpc_pkg::DPC_ACT;
            3'h4: return dpc_pkg::DPC_WR;
            3'h5: return dpc_pkg::DPC_RD;
            default: return dpc_pkg::DPC_NOP;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic results();
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Pulse counters; each read beat checked on the cycle after it loads
    always @(posedge sys_clk) begin
        rd_data <= 8'(rnd());
        rd_q <= (rd_beat === 1'b1);
        rd_prev <= rd_data;
        if (rd_beat === 1'b1) n_beat <= n_beat + 1;
        if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
        if (wr_overrun === 1'b1) n_ovr <= n_ovr + 1;
        if (rd_q) begin
            chk(dq_out, rd_prev);
            chk({dq_oe, dqs_out}, {1'b1, n_beat[0]});
        end
    end
    // A hang ends the run as a failure
    initial begin
        repeat (50000) @(posedge sys_clk);
        fails++;
        results();
    end

    initial begin
        rst = 1'b1;
        wr_ready = 1'b0;
        rd_data = 8'h00;
        rd_q = 1'b0;
        {fails, n_tests, n_cmd, n_ovr, n_beat, x_ovr} = '0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        // Every code once; bank number follows the code so the mode write hits bank 0
        for (int r = 0; r < 8; r++) begin
            a = 14'(rnd());
            c0 = n_cmd;
            m.cmd(1'b0, 3'(r), 2'(r), a);
            chk(n_cmd - c0, 1);
            chk(cmd_code, dec(3'(r)));
            chk({cmd_bank, cmd_addr}, {2'(r), a});
            chk(bank_open, (r >= 3) ? 4'h8 : 4'h0);
        end
        c0 = n_cmd;
        m.cmd(1'b1, dpc_pkg::RCW_ACT, 2'h0, 14'h0000);
        chk(n_cmd - c0, 0);
        repeat (3) m.cmd(1'b1, 3'h7, 2'h0, 14'h0000);
        chk(n_beat, 4);
        chk({dq_oe, dqs_oe}, 2'h0);
        // Power-down with a row open refuses commands until the exit
        m.pins(1'b0, 1'b0);
        m.cmd(1'b1, 3'h7, 2'h0, 14'h0000);
        chk(pwr_state, dpc_pkg::DPC_PD_ACT);
        c0 = n_cmd;
        m.cmd(1'b0, dpc_pkg::RCW_PRE, 2'h3, 14'h0400);
        chk(n_cmd - c0, 0);
        m.pins(1'b1, 1'b0);
        m.cmd(1'b1, 3'h7, 2'h0, 14'h0000);
        chk(pwr_state, dpc_pkg::DPC_ACTIVE);
        m.cmd(1'b0, dpc_pkg::RCW_ACT, 2'h1, 14'h0000);
        m.cmd(1'b0, dpc_pkg::RCW_PRE, 2'h3, 14'h0000);
        chk(bank_open, 4'h2);
        m.cmd(1'b0, dpc_pkg::RCW_PRE, 2'h0, 14'h0400);
        chk(bank_open, 4'h0);
        // Self refresh, left with the clock parked
        m.pins(1'b0, 1'b0);
        m.cmd(1'b0, dpc_pkg::RCW_REF, 2'h0, 14'h0000);
        chk(pwr_state, dpc_pkg::DPC_SELF_REF);
        m.pins(1'b1, 1'b0);
        for (int i = 0; i < 8 && pwr_state !== dpc_pkg::DPC_ACTIVE; i++) @(posedge sys_clk);
        chk(pwr_state, dpc_pkg::DPC_ACTIVE);
        // Termination on, then read strobe mode, then off with the pin still high
        m.cmd(1'b0, dpc_pkg::RCW_MRS, dpc_pkg::BANK_EMR1, 14'h0004);
        m.pins(1'b1, 1'b1);
        m.cmd(1'b1, 3'h7, 2'h0, 14'h0000);
        chk({term_dq, term_dqs, term_dm, term_rdqs, term_upper}, 5'h1C);
        m.cmd(1'b0, dpc_pkg::RCW_MRS, dpc_pkg::BANK_EMR1, 14'h0840);
        chk({term_dq, term_dqs, term_dm, term_rdqs, term_upper}, 5'h1A);
        m.cmd(1'b0, dpc_pkg::RCW_MRS, dpc_pkg::BANK_EMR1, 14'h0000);
        m.cmd(1'b1, 3'h7, 2'h0, 14'h0000);
        chk({term_dq, term_dqs, term_dm, term_rdqs, term_upper}, 5'h00);
        m.pins(1'b1, 1'b0);
        // Eleven bursts with random masks into a stalled FIFO, then drain
        for (int k = 0; k < 44; k++) begin
            if (k % 4 == 0) m.cmd(1'b0, dpc_pkg::RCW_WR, 2'h0, 14'h0000);
            d = 8'(rnd());
            mk = (rnd() % 8) == 0;
            m.beat(mk, d);
            if (!mk && exp_q.size() < dpc_pkg::FIFO_DEPTH) exp_q.push_back(d);
            else if (!mk) x_ovr++;
        end
        repeat (4) @(posedge sys_clk);
        chk(n_ovr, x_ovr);
        wr_ready <= 1'b1;
        for (int i = 0; i < 100 && exp_q.size() > 0; i++) begin
            @(posedge sys_clk);
            if (wr_valid === 1'b1) chk(wr_data, exp_q.pop_front());
        end
        chk(exp_q.size(), 0);
        @(posedge sys_clk);
        chk(wr_valid, 1'b0);
        results();
    end
endmodule
`default_nettype wire
